// ==== bench/pin_board_model.sv ====
// pin_board_model: board logic that drives or samples the multifunction pins
// assumes the router's pin drive and enable, and drive requests from the bench
`timescale 1ns/1ps
`default_nettype none
module pin_board_model
(
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] pin_oe_n_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] drv_en_i,
    output var  logic [7:0] level_o
);
    logic [7:0] last = 8'h00;

    // ----------------------------------------
    // wire level
    // ----------------------------------------
    // router wins where it drives; a floating pin shows a changing level
    always_comb
    begin
        for (int n = 0; n < 8; n++)
        begin
            level_o[n] = !pin_oe_n_i[n] ? pin_o_i[n] : (drv_en_i[n] ? drv_i[n] : ~last[n]);
        end
    end

    always @(posedge clk_i)
    begin
        last <= level_o;
    end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// testbench: self-checking bench for the multifunction pin router
// assumes the router package, the router and the board model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mf_pin_pkg::*;
    localparam int SW = $bits(mf_status_t);
    localparam mf_reg_req_t IDLE = '0;
    localparam logic [2:0] DMAP [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h4, 3'h5, 3'h7};
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    mf_reg_req_t req = IDLE;
    mf_status_t  status = '0;
    logic [7:0]  drv = 8'h00;
    logic [7:0]  drv_en = 8'hFF;
    logic [7:0]  pin_lvl, pin_out, pin_oe_n, strap, rdata;
    logic        rvalid, strap_valid;
    mf_control_t ctl;
    int          fails = 0;
    int          checks = 0;

    always #4 clk = ~clk;

    multifunction_pin_router dut (.clk_i(clk), .nrst_i(nrst), .reg_req_i(req),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .status_i(status), .control_o(ctl),
        .pin_i(pin_lvl), .pin_o(pin_out), .pin_oe_n_o(pin_oe_n), .strap_o(strap),
        .strap_valid_o(strap_valid));
    pin_board_model board (.clk_i(clk), .pin_o_i(pin_out), .pin_oe_n_i(pin_oe_n),
        .drv_i(drv), .drv_en_i(drv_en), .level_o(pin_lvl));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= IDLE;
    endtask

    task automatic reg_expect(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= IDLE;
        #1;
        check_val(32'(rvalid), 32'h1);
        check_val(32'(rdata), 32'(exp));
    endtask

    function automatic logic exp_out(input logic [6:0] c, input mf_status_t s);
        case (c) inside
            7'h01: return 1'b1;
            7'h03: return s.watchdog_timeout;
            [7'h04:7'h06]: return s.eeprom[c[1:0]];
            7'h07: return s.system_clock_multiplier[0];
            7'h08: return s.system_clock_multiplier[1];
            7'h0B: return s.system_clock_multiplier[4];
            [7'h10:7'h17]: return s.dpll[DMAP[c[2:0]]];
            7'h18: return s.loop_ext[7];
            7'h19: return s.loop_ext[6];
            7'h1A: return s.twh_updated;
            [7'h20:7'h23]: return s.ref_status[c[1:0]][2];
            [7'h30:7'h33]: return s.ref_status[c[1:0]][3];
            [7'h40:7'h43]: return s.loop_ext[1:0] == c[1:0];
            7'h50: return s.dist_sync_pulse;
            default: return 1'b0;
        endcase
    endfunction

    function automatic mf_control_t exp_ctl(input logic [6:0] c);
        mf_control_t k;
        k = '0;
        case (c) inside
            7'h01: k.io_update = 1'b1;
            7'h02: k.power_down = 1'b1;
            7'h03: k.watchdog_reset = 1'b1;
            7'h04: k.irq_clear = 1'b1;
            7'h05: k.twh_reset = 1'b1;
            7'h10: k.force_holdover = 1'b1;
            7'h11: k.force_freerun = 1'b1;
            7'h12: k.ipo_reset = 1'b1;
            7'h13: k.ipo_inc = 1'b1;
            7'h14: k.ipo_dec = 1'b1;
            [7'h20:7'h23]: k.ref_override[c[1:0]] = 1'b1;
            [7'h30:7'h33]: k.force_validation[c[1:0]] = 1'b1;
            7'h40: k.out_enable[0] = 1'b1;
            7'h41: k.out_enable[1] = 1'b1;
            7'h44: k.out_enable = 2'h3;
            default: ;
        endcase
        return k;
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic reset_and_straps(input logic [7:0] pat);
        @(posedge clk);
        nrst <= 1'b0;
        drv_en <= 8'hFF;
        drv <= pat;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        cycles(8);
        check_val(32'(pin_oe_n), 32'hFF);
        check_val(32'(pin_out), 32'h0);
        check_val(32'(ctl), 32'h0);
        check_val(32'(strap_valid), 32'h1);
        for (int n = 0; n < 8; n++)
            reg_expect(CFG_BASE + 16'(n), 8'h00);
        drv <= ~pat;
        cycles(6);
        check_val(32'(strap), 32'(pat));
    endtask

    task automatic registers();
        for (int n = 0; n < 8; n++)
            reg_write(CFG_BASE + 16'(n), 8'(n * 17));
        for (int n = 0; n < 8; n++)
            reg_expect(CFG_BASE + 16'(n), 8'(n * 17));
        check_val(32'(pin_oe_n), 32'hFF);
        reg_write(16'h0208, 8'h7F);
        reg_write(16'h01FF, 8'h7F);
        reg_expect(16'h0208, 8'h00);
        reg_expect(16'h0200, 8'h00);
        reg_expect(16'h0207, 8'h77);
        for (int n = 0; n < 8; n++)
            reg_write(CFG_BASE + 16'(n), 8'h00);
    endtask

    task automatic out_functions();
        logic [63:0] pats [4] = '{64'h0, '1, 64'h5A3C_96E1_0F87_D24B, 64'hA5C3_691E_F078_2DB4};
        @(posedge clk);
        drv_en <= 8'hFC;
        foreach (pats[p])
        begin
            @(posedge clk);
            status <= mf_status_t'(SW'(pats[p]));
            for (int c = 0; c < 128; c++)
            begin
                if (c == 2)
                    continue;
                reg_write(CFG_BASE, 8'h80 | 8'(c));
                cycles(2);
                check_val(32'(pin_oe_n[0]), 32'h0);
                check_val(32'(pin_out[0]), 32'(exp_out(7'(c), status)));
            end
        end
    endtask

    task automatic divider_output();
        int hi;
        int lo;
        int n;
        reg_write(CFG_BASE + 16'h1, 8'h82);
        cycles(2);
        n = 0;
        while (pin_out[1] !== 1'b0 && n < 40)
        begin
            cycles(1);
            n++;
        end
        while (pin_out[1] !== 1'b1 && n < 80)
        begin
            cycles(1);
            n++;
        end
        hi = 0;
        lo = 0;
        while (pin_out[1] === 1'b1 && hi < 40)
        begin
            cycles(1);
            hi++;
        end
        while (pin_out[1] === 1'b0 && lo < 40)
        begin
            cycles(1);
            lo++;
        end
        check_val(32'(hi), 32'h10);
        check_val(32'(lo), 32'h10);
    endtask

    task automatic in_functions();
        for (int c = 0; c < 128; c++)
        begin
            if (c == 69)
                continue;
            reg_write(CFG_BASE + 16'h2, 8'(c));
            @(posedge clk);
            drv <= 8'h04;
            cycles(2);
            check_val(32'(ctl), 32'h0);
            cycles(2);
            check_val(32'(ctl), 32'(exp_ctl(7'(c))));
            drv <= 8'h00;
            cycles(4);
            check_val(32'(ctl), 32'h0);
        end
    endtask

    task automatic priority_pins();
        @(posedge clk);
        drv_en <= 8'hFF;
        drv <= 8'h20;
        reg_write(CFG_BASE + 16'h1, 8'h02);
        reg_write(CFG_BASE + 16'h5, 8'h02);
        cycles(4);
        check_val(32'(ctl.power_down), 32'h0);
        drv <= 8'h02;
        cycles(4);
        check_val(32'(ctl.power_down), 32'h1);
        reg_write(CFG_BASE + 16'h1, 8'h44);
        reg_write(CFG_BASE + 16'h5, 8'h40);
        drv <= 8'h20;
        cycles(4);
        check_val(32'(ctl.out_enable), 32'h0);
        drv <= 8'h02;
        cycles(4);
        check_val(32'(ctl.out_enable), 32'h3);
    endtask

    task automatic count_sync(output int n);
        n = 0;
        repeat (10)
        begin
            cycles(1);
            n += int'(ctl.dist_sync_request === 1'b1);
        end
    endtask

    task automatic sync_request();
        int n;
        drv <= 8'h00;
        reg_write(CFG_BASE + 16'h3, 8'h45);
        @(posedge clk);
        drv <= 8'h08;
        count_sync(n);
        check_val(32'(n), 32'h0);
        drv <= 8'h00;
        count_sync(n);
        check_val(32'(n), 32'h1);
    endtask

    initial
    begin
        fork
            begin
                repeat (30000) @(posedge clk);
                fails++;
                complete_run();
            end
        join_none
        reset_and_straps(8'hA5);
        registers();
        out_functions();
        divider_output();
        in_functions();
        priority_pins();
        sync_request();
        reset_and_straps(8'h3C);
        complete_run();
    end
endmodule
`default_nettype wire

// ==== rtl/mf_pin_pkg.sv ====
// mf_pin_pkg: constants, codes and carrier types for the pin router
// assumes a single system clock domain and byte-wide register access
package mf_pin_pkg;

    localparam int          NUM_PINS    = 8;
    localparam int          DIR_BIT     = 7;
    localparam logic [15:0] CFG_BASE    = 16'h0200;
    localparam logic [15:0] CFG_LAST    = 16'h0207;
    localparam logic [7:0]  CFG_RESET   = 8'h00;
    localparam logic [1:0]  STRAP_DELAY = 2'h3;

    // output function codes (direction bit set)
    localparam logic [6:0] OF_HIGH       = 7'h01;
    localparam logic [6:0] OF_DIV32      = 7'h02;
    localparam logic [6:0] OF_WDOG       = 7'h03;
    localparam logic [6:0] OF_EE_BASE    = 7'h04;
    localparam logic [6:0] OF_EE_LAST    = 7'h06;
    localparam logic [6:0] OF_SYS_LOCK   = 7'h07;
    localparam logic [6:0] OF_SYS_CAL    = 7'h08;
    localparam logic [6:0] OF_SYS_STABLE = 7'h0B;
    localparam logic [6:0] OF_DPLL_BASE  = 7'h10;
    localparam logic [6:0] OF_DPLL_LAST  = 7'h17;
    localparam logic [6:0] OF_CLAMP      = 7'h18;
    localparam logic [6:0] OF_TWH_AVAIL  = 7'h19;
    localparam logic [6:0] OF_TWH_UPD    = 7'h1A;
    localparam logic [6:0] OF_FAULT_BASE = 7'h20;
    localparam logic [6:0] OF_FAULT_LAST = 7'h23;
    localparam logic [6:0] OF_VALID_BASE = 7'h30;
    localparam logic [6:0] OF_VALID_LAST = 7'h33;
    localparam logic [6:0] OF_ACT_BASE   = 7'h40;
    localparam logic [6:0] OF_ACT_LAST   = 7'h43;
    localparam logic [6:0] OF_SYNC       = 7'h50;

    // input function codes (direction bit clear)
    localparam logic [6:0] IF_IO_UPDATE  = 7'h01;
    localparam logic [6:0] IF_PWRDN      = 7'h02;
    localparam logic [6:0] IF_WDOG_RST   = 7'h03;
    localparam logic [6:0] IF_IRQ_CLR    = 7'h04;
    localparam logic [6:0] IF_TWH_RST    = 7'h05;
    localparam logic [6:0] IF_HOLDOVER   = 7'h10;
    localparam logic [6:0] IF_FREERUN    = 7'h11;
    localparam logic [6:0] IF_IPO_RST    = 7'h12;
    localparam logic [6:0] IF_IPO_INC    = 7'h13;
    localparam logic [6:0] IF_IPO_DEC    = 7'h14;
    localparam logic [6:0] IF_OVR_BASE   = 7'h20;
    localparam logic [6:0] IF_FVT_BASE   = 7'h30;
    localparam logic [6:0] IF_CLOCK_OUTPUT_ZERO_EN    = 7'h40;
    localparam logic [6:0] IF_CLOCK_OUTPUT_ONE_EN    = 7'h41;
    localparam logic [6:0] IF_OUT_BOTH   = 7'h44;
    localparam logic [6:0] IF_SYNC       = 7'h45;

    // status bit positions
    localparam int SYS_LOCK_BIT   = 0;
    localparam int SYS_CAL_BIT    = 1;
    localparam int SYS_STABLE_BIT = 4;
    localparam int CLAMP_BIT      = 7;
    localparam int TWH_AVAIL_BIT  = 6;
    localparam int REF_FAULT_BIT  = 2;
    localparam int REF_VALID_BIT  = 3;
    // loop state bit for codes 16..23, in code order
    localparam logic [2:0] DPLL_BIT [0:7] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                              3'h6, 3'h4, 3'h5, 3'h7};

    typedef struct packed {
        logic            watchdog_timeout;
        logic [2:0]      eeprom;
        logic [4:0]      system_clock_multiplier;
        logic [7:0]      dpll;
        logic [7:0]      loop_ext;
        logic            twh_updated;
        logic [3:0][7:0] ref_status;
        logic            dist_sync_pulse;
    } mf_status_t;

    typedef struct packed {
        logic       io_update;
        logic       power_down;
        logic       watchdog_reset;
        logic       irq_clear;
        logic       twh_reset;
        logic       force_holdover;
        logic       force_freerun;
        logic       ipo_reset;
        logic       ipo_inc;
        logic       ipo_dec;
        logic [3:0] ref_override;
        logic [3:0] force_validation;
        logic [1:0] out_enable;
        logic       dist_sync_request;
    } mf_control_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mf_reg_req_t;

    typedef struct packed {
        logic [7:0][7:0] cfg;
        logic [7:0]      sync1;
        logic [7:0]      sync2;
        logic [4:0]      div_cnt;
        mf_control_t     ctl;
        logic            sync_prev;
        logic [7:0]      pin_out;
        logic [7:0]      pin_oe_n;
        logic [7:0]      rdata;
        logic            rvalid;
        logic [7:0]      strap;
        logic            strap_valid;
        logic [1:0]      strap_cnt;
    } mf_state_t;

    localparam mf_state_t STATE_RST = '{pin_oe_n: 8'hFF, default: '0};

endpackage

// ==== rtl/multifunction_pin_router.sv ====
// multifunction_pin_router: eight configurable status/control pins
// assumes the register port is synchronous to clk_i; pins pass a two-flop synchronizer
`timescale 1ns/1ps
`default_nettype none

module multifunction_pin_router
(
    input  wire logic                     clk_i,
    input  wire logic                     nrst_i,
    input  wire mf_pin_pkg::mf_reg_req_t  reg_req_i,
    output var  logic [7:0]               reg_rdata_o,
    output var  logic                     reg_rvalid_o,
    input  wire mf_pin_pkg::mf_status_t   status_i,
    output var  mf_pin_pkg::mf_control_t  control_o,
    input  wire logic [7:0]               pin_i,
    output var  logic [7:0]               pin_o,
    output var  logic [7:0]               pin_oe_n_o,
    output var  logic [7:0]               strap_o,
    output var  logic                     strap_valid_o
);
    import mf_pin_pkg::*;

    logic [1:0] rst_ff;
    logic       rst_n;
    mf_state_t  state;
    mf_state_t  next_state;

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_ff <= 2'h0;
        else
            rst_ff <= {rst_ff[0], 1'b1};
    end
    assign rst_n = rst_ff[1];

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    function automatic logic out_func(input logic [6:0] code, input mf_status_t st,
                                      input logic div);
        logic       r;
        logic [6:0] off;
        r = 1'b0;
        off = 7'h00;
        if (code == OF_HIGH)
            r = 1'b1;
        else if (code == OF_DIV32)
            r = div;
        else if (code == OF_WDOG)
            r = st.watchdog_timeout;
        else if (code >= OF_EE_BASE && code <= OF_EE_LAST)
        begin
            off = code - OF_EE_BASE;
            r = st.eeprom[off[1:0]];
        end
        else if (code == OF_SYS_LOCK)
            r = st.system_clock_multiplier[SYS_LOCK_BIT];
        else if (code == OF_SYS_CAL)
            r = st.system_clock_multiplier[SYS_CAL_BIT];
        else if (code == OF_SYS_STABLE)
            r = st.system_clock_multiplier[SYS_STABLE_BIT];
        else if (code >= OF_DPLL_BASE && code <= OF_DPLL_LAST)
        begin
            off = code - OF_DPLL_BASE;
            r = st.dpll[DPLL_BIT[off[2:0]]];
        end
        else if (code == OF_CLAMP)
            r = st.loop_ext[CLAMP_BIT];
        else if (code == OF_TWH_AVAIL)
            r = st.loop_ext[TWH_AVAIL_BIT];
        else if (code == OF_TWH_UPD)
            r = st.twh_updated;
        else if (code >= OF_FAULT_BASE && code <= OF_FAULT_LAST)
        begin
            off = code - OF_FAULT_BASE;
            r = st.ref_status[off[1:0]][REF_FAULT_BIT];
        end
        else if (code >= OF_VALID_BASE && code <= OF_VALID_LAST)
        begin
            off = code - OF_VALID_BASE;
            r = st.ref_status[off[1:0]][REF_VALID_BIT];
        end
        else if (code >= OF_ACT_BASE && code <= OF_ACT_LAST)
        begin
            off = code - OF_ACT_BASE;
            r = (st.loop_ext[1:0] == off[1:0]);
        end
        else if (code == OF_SYNC)
            r = st.dist_sync_pulse;
        return r;
    endfunction

    // level of the lowest-index input pin carrying code a or b
    function automatic logic pick(input logic [6:0] a, input logic [6:0] b,
                                  input logic [7:0][7:0] cfg, input logic [7:0] lvl);
        logic r;
        r = 1'b0;
        for (int i = NUM_PINS - 1; i >= 0; i--)
        begin
            if (!cfg[i][DIR_BIT] && (cfg[i][6:0] == a || cfg[i][6:0] == b))
                r = lvl[i];
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        logic       sync_lvl;
        logic [6:0] code;
        sync_lvl = 1'b0;
        code = 7'h00;
        next_state = state;

        next_state.sync1 = pin_i;
        next_state.sync2 = state.sync1;
        next_state.div_cnt = state.div_cnt + 5'h01;

        // register port
        next_state.rvalid = 1'b0;
        next_state.rdata = 8'h00;
        if (reg_req_i.addr >= CFG_BASE && reg_req_i.addr <= CFG_LAST)
        begin
            if (reg_req_i.wr)
                next_state.cfg[reg_req_i.addr[2:0]] = reg_req_i.wdata;
            if (reg_req_i.rd)
                next_state.rdata = state.cfg[reg_req_i.addr[2:0]];
        end
        if (reg_req_i.rd)
            next_state.rvalid = 1'b1;

        // pin outputs
        for (int i = 0; i < NUM_PINS; i++)
        begin
            if (state.cfg[i][DIR_BIT])
            begin
                // unused codes fall through to low
                next_state.pin_out[i] = out_func(state.cfg[i][6:0], status_i,
                                                 state.div_cnt[4]);
                next_state.pin_oe_n[i] = 1'b0;
            end
            else
            begin
                next_state.pin_out[i] = 1'b0;
                next_state.pin_oe_n[i] = 1'b1;
            end
        end

        // input controls, code 0 matches nothing
        next_state.ctl.io_update      = pick(IF_IO_UPDATE, IF_IO_UPDATE, state.cfg,
                                             state.sync2);
        next_state.ctl.power_down     = pick(IF_PWRDN, IF_PWRDN, state.cfg,
                                             state.sync2);
        next_state.ctl.watchdog_reset = pick(IF_WDOG_RST, IF_WDOG_RST, state.cfg,
                                             state.sync2);
        next_state.ctl.irq_clear      = pick(IF_IRQ_CLR, IF_IRQ_CLR, state.cfg,
                                             state.sync2);
        next_state.ctl.twh_reset      = pick(IF_TWH_RST, IF_TWH_RST, state.cfg,
                                             state.sync2);
        next_state.ctl.force_holdover = pick(IF_HOLDOVER, IF_HOLDOVER, state.cfg,
                                             state.sync2);
        next_state.ctl.force_freerun  = pick(IF_FREERUN, IF_FREERUN, state.cfg,
                                             state.sync2);
        next_state.ctl.ipo_reset      = pick(IF_IPO_RST, IF_IPO_RST, state.cfg,
                                             state.sync2);
        next_state.ctl.ipo_inc        = pick(IF_IPO_INC, IF_IPO_INC, state.cfg,
                                             state.sync2);
        next_state.ctl.ipo_dec        = pick(IF_IPO_DEC, IF_IPO_DEC, state.cfg,
                                             state.sync2);
        for (int k = 0; k < 4; k++)
        begin
            code = IF_OVR_BASE + 7'(k);
            next_state.ctl.ref_override[k] = pick(code, code, state.cfg,
                                                  state.sync2);
            code = IF_FVT_BASE + 7'(k);
            next_state.ctl.force_validation[k] = pick(code, code, state.cfg,
                                                      state.sync2);
        end
        next_state.ctl.out_enable[0] = pick(IF_CLOCK_OUTPUT_ZERO_EN, IF_OUT_BOTH, state.cfg,
                                            state.sync2);
        next_state.ctl.out_enable[1] = pick(IF_CLOCK_OUTPUT_ONE_EN, IF_OUT_BOTH, state.cfg,
                                            state.sync2);

        // sync request on falling edge of the selected level
        sync_lvl = pick(IF_SYNC, IF_SYNC, state.cfg, state.sync2);
        next_state.sync_prev = sync_lvl;
        next_state.ctl.dist_sync_request = state.sync_prev & ~sync_lvl;

        // strap capture once the synchronizer has settled
        if (!state.strap_valid)
        begin
            if (state.strap_cnt == STRAP_DELAY)
            begin
                next_state.strap = state.sync2;
                next_state.strap_valid = 1'b1;
            end
            else
                next_state.strap_cnt = state.strap_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            state <= STATE_RST;
        else
            state <= next_state;
    end

    assign reg_rdata_o   = state.rdata;
    assign reg_rvalid_o  = state.rvalid;
    assign control_o     = state.ctl;
    assign pin_o         = state.pin_out;
    assign pin_oe_n_o    = state.pin_oe_n;
    assign strap_o       = state.strap;
    assign strap_valid_o = state.strap_valid;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence pins_steady;
        $stable(pin_i) [*3] ##0 $past(rst_n, 2);
    endsequence

    sequence pwrdn_on_both;
        state.cfg[0] != {1'b0, IF_PWRDN}
        && !state.cfg[1][DIR_BIT] && state.cfg[1][6:0] == IF_PWRDN
        && !state.cfg[5][DIR_BIT] && state.cfg[5][6:0] == IF_PWRDN;
    endsequence

    a_out_dir_drive: assert property (state.cfg[0][DIR_BIT] |=> !pin_oe_n_o[0])
        else $error("output pin not driven");
    a_in_dir_release: assert property (!state.cfg[0][DIR_BIT] |=> pin_oe_n_o[0] && !pin_o[0])
        else $error("input pin driven");
    a_const_high: assert property (state.cfg[0] == {1'b1, OF_HIGH} |=> pin_o[0])
        else $error("constant high missing");
    a_div_half: assert property ($changed(state.div_cnt[4]) |-> ##1 $stable(state.div_cnt[4]) [*8])
        else $error("divider half period short");
    a_unused_low: assert property (state.cfg[0][DIR_BIT] && state.cfg[0][6:0] > OF_SYNC
                                   |=> !pin_o[0])
        else $error("unused output code not low");
    a_lowest_wins: assert property (pwrdn_on_both |=> control_o.power_down
                                    == $past(state.sync2[1]))
        else $error("priority not lowest pin");
    a_sync_falling: assert property (control_o.dist_sync_request |-> !state.sync_prev
                                     && $past(state.sync_prev))
        else $error("sync request without falling edge");
    a_sync_settle: assert property (pins_steady |-> state.sync2 == pin_i)
        else $error("synchronizer not settled");
    a_idle_default: assert property (state.cfg == '0 |=> control_o == '0)
        else $error("default config drives control");
    a_strap_hold: assert property (state.strap_valid && $past(state.strap_valid)
                                   |-> $stable(state.strap))
        else $error("strap changed after capture");
    a_cfg_readback: assert property (reg_req_i.rd && reg_req_i.addr == CFG_BASE
                                     |=> reg_rvalid_o && reg_rdata_o == $past(state.cfg[0]))
        else $error("register readback wrong");

    // selected status reaches an output pin one edge later
    sequence pin0_shows(logic [6:0] c);
        state.cfg[0] == {1'b1, c};
    endsequence

    a_div_follow: assert property (state.cfg[1] == {1'b1, OF_DIV32} |=>
        pin_o[1] == $past(state.div_cnt[4]))
        else $error("divided clock not on pin");
    a_wdog_follow: assert property (pin0_shows(OF_WDOG) |=>
        pin_o[0] == $past(status_i.watchdog_timeout))
        else $error("watchdog timeout not on pin");
    a_store_follow: assert property (pin0_shows(OF_EE_BASE) |=>
        pin_o[0] == $past(status_i.eeprom[0]))
        else $error("store upload flag not on pin");
    a_stable_follow: assert property (pin0_shows(OF_SYS_STABLE) |=>
        pin_o[0] == $past(status_i.system_clock_multiplier[SYS_STABLE_BIT]))
        else $error("multiplier stable flag not on pin");
    a_clamp_follow: assert property (pin0_shows(OF_CLAMP) |=>
        pin_o[0] == $past(status_i.loop_ext[CLAMP_BIT]))
        else $error("clamp flag not on pin");
    a_fault_follow: assert property (pin0_shows(OF_FAULT_LAST) |=>
        pin_o[0] == $past(status_i.ref_status[3][REF_FAULT_BIT]))
        else $error("reference fault flag not on pin");
    a_valid_follow: assert property (pin0_shows(OF_VALID_BASE) |=>
        pin_o[0] == $past(status_i.ref_status[0][REF_VALID_BIT]))
        else $error("reference valid flag not on pin");
    a_active_ref: assert property (pin0_shows(OF_ACT_LAST) |=>
        pin_o[0] == ($past(status_i.loop_ext[1:0]) == 2'h3))
        else $error("active reference decode wrong");
    a_sync_out: assert property (pin0_shows(OF_SYNC) |=>
        pin_o[0] == $past(status_i.dist_sync_pulse))
        else $error("sync pulse not on pin");
    a_read_pulse: assert property (reg_req_i.rd |=> reg_rvalid_o)
        else $error("read without valid");
    a_read_quiet: assert property (!reg_req_i.rd |=> !reg_rvalid_o)
        else $error("valid without read");
    a_in_level: assert property (state.cfg[2] == {1'b0, IF_IO_UPDATE}
        && state.cfg[0][DIR_BIT] && state.cfg[1][DIR_BIT]
        |=> control_o.io_update == $past(state.sync2[2]))
        else $error("update strobe not following pin");
    a_outen_both: assert property (state.cfg[1] == {1'b0, IF_OUT_BOTH}
        && state.cfg[0][DIR_BIT] |=> control_o.out_enable == {2{$past(state.sync2[1])}})
        else $error("both output enables not following pin");
    a_strap_capture: assert property ($rose(strap_valid_o) |->
        strap_o == $past(state.sync2))
        else $error("strap not taken from synchronized pins");

endmodule

`default_nettype wire
